// *** hdl/speed_torque_regulator.sv ***
// speed pi regulator, torque reference scaling and mode selection
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`include "strg_cfg.svh"

// Function
// [RULE1] error is speed reference minus feedback, shaped by proportional and integral terms
// [RULE2] integral accumulates error times integral_gain, per-unit torque per second
// [RULE3] proportional output equals proportional_gain times per-unit error
// [RULE4] nonzero loop_bandwidth makes the device compute both gains, zero leaves manual
// [RULE5] writing loop_bandwidth or inertia recalculates both gains
// [RULE6] feedforward_gain damps speed changes; feed-forward open during auto-tune
// [RULE7] inertia is seconds to base speed at rated torque; tune stores it
// [RULE8] mode 0 commands zero torque current, motor kept fluxed
// [RULE9] mode 1 uses speed regulator output
// [RULE10] mode 2 uses final external torque reference
// [RULE11] mode 3 algebraic minimum, mode 4 algebraic maximum
// [RULE12] min and max modes switch per sample by comparison winner
// [RULE13] mode 5 sums speed regulator output and torque reference
// [RULE14] torque source A scaled between high and low, then divided
// [RULE15] torque source B scaled between high and low, then multiplied
// [RULE16] final torque reference is sum of scaled sources
// [RULE17] codes above 5 give zero torque; one update per sample; reset clears
module strg_speed_torque_regulator
    import strg_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire strg_inputs_type ctlIn,
    input wire logic inertiaValid,
    input wire logic [15:0] inertiaMeasured,
    output strg_outputs_type ctlOut
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // q12 fixed point: 4096 = 1.0 per unit
    function automatic logic signed [15:0] strg_sat(input logic signed [47:0] v);
        if (v > 48'sd32767) begin
            return 16'sh7FFF;
        end else if (v < -48'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : strg_sat

    // scale source (q12, 0..1 span) linearly between low and high
    function automatic logic signed [47:0] strg_scale(input logic signed [15:0] src,
                                                      input logic signed [15:0] hi,
                                                      input logic signed [15:0] lo);
        logic signed [47:0] span;
        span = 48'(hi) - 48'(lo);
        return 48'(lo) + ((48'(src) * span) >>> 12);
    endfunction : strg_scale

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [2:0] mode_q;
    logic [15:0] bandwidth_q;
    logic [15:0] inertia_q;
    logic [15:0] ki_q;
    logic [15:0] kp_q;
    logic [15:0] kf_q;
    logic signed [15:0] aHi_q;
    logic signed [15:0] aLo_q;
    logic [15:0] aDiv_q;
    logic signed [15:0] bHi_q;
    logic signed [15:0] bLo_q;
    logic [15:0] bMult_q;
    logic [1:0] ctrl_q;
    logic recalc_q;
    logic wbAck_q;
    logic [31:0] wbDat_q;
    logic wbWrite;
    logic [15:0] wData;

    assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wbAck_q;

    // merge byte lanes into the low half word
    function automatic logic [15:0] strg_lanes(input logic [15:0] old);
        logic [15:0] r;
        r = old;
        if (wb_sel_i[0]) begin
            r[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            r[15:8] = wb_dat_i[15:8];
        end
        return r;
    endfunction : strg_lanes

    assign wData = wb_dat_i[15:0];

    // ----------------------------------------
    // bus slave: ack one cycle after request
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wbAck_q <= 1'b0;
        end else begin
            wbAck_q <= wb_cyc_i && wb_stb_i && !wbAck_q;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 3'h0;
            bandwidth_q <= 16'h0000;
            kf_q <= `STRG_RST_KF;
            aHi_q <= `STRG_RST_A_HI;
            aLo_q <= 16'h0000;
            aDiv_q <= `STRG_RST_A_DIV;
            bHi_q <= `STRG_RST_B_HI;
            bLo_q <= 16'h0000;
            bMult_q <= `STRG_RST_B_MULT;
            ctrl_q <= 2'h0;
        end else if (wbWrite) begin
            case (wb_adr_i)
                `STRG_OFF_MODE: mode_q <= wb_sel_i[0] ? wData[2:0] : mode_q;
                `STRG_OFF_BW: bandwidth_q <= strg_lanes(bandwidth_q);
                `STRG_OFF_KF: kf_q <= strg_lanes(kf_q);
                `STRG_OFF_A_HI: aHi_q <= strg_lanes(aHi_q);
                `STRG_OFF_A_LO: aLo_q <= strg_lanes(aLo_q);
                `STRG_OFF_A_DIV: aDiv_q <= strg_lanes(aDiv_q);
                `STRG_OFF_B_HI: bHi_q <= strg_lanes(bHi_q);
                `STRG_OFF_B_LO: bLo_q <= strg_lanes(bLo_q);
                `STRG_OFF_B_MULT: bMult_q <= strg_lanes(bMult_q);
                `STRG_OFF_CTRL: ctrl_q <= wb_sel_i[0] ? wData[1:0] : ctrl_q;
                default: ;
            endcase
        end
    end

    // inertia: written by software or stored by the inertia tune
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            inertia_q <= `STRG_RST_INERTIA;
        end else if (ctrl_q[`STRG_CTRL_INERTIA_TUNE] && inertiaValid) begin
            inertia_q <= inertiaMeasured; // RULE7
        end else if (wbWrite && wb_adr_i == `STRG_OFF_INERTIA) begin
            inertia_q <= strg_lanes(inertia_q);
        end
    end

    // a write to bandwidth or inertia, or a tuned inertia, asks for new gains
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            recalc_q <= 1'b0;
        end else begin
            recalc_q <= wbWrite && (wb_adr_i == `STRG_OFF_BW
                        || wb_adr_i == `STRG_OFF_INERTIA)
                        || (ctrl_q[`STRG_CTRL_INERTIA_TUNE] && inertiaValid); // RULE5
        end
    end

    // gains: computed kp = bw * inertia / 256, ki = kp * bw / 4 when bandwidth nonzero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ki_q <= `STRG_RST_KI;
            kp_q <= `STRG_RST_KP;
        end else if (recalc_q && bandwidth_q != 16'h0000) begin
            kp_q <= 16'((32'(bandwidth_q) * 32'(inertia_q)) >> 8); // RULE4 RULE5
            ki_q <= 16'((32'(bandwidth_q) * 32'(bandwidth_q) * 32'(inertia_q)) >> 10);
        end else if (wbWrite && bandwidth_q == 16'h0000) begin
            if (wb_adr_i == `STRG_OFF_KI) begin
                ki_q <= strg_lanes(ki_q); // RULE4
            end
            if (wb_adr_i == `STRG_OFF_KP) begin
                kp_q <= strg_lanes(kp_q);
            end
        end
    end

    // ----------------------------------------
    // sample period enable
    // ----------------------------------------
    logic [15:0] sampleCnt_q;
    logic sampleTick;
    assign sampleTick = sampleCnt_q == 16'(`STRG_SAMPLE_CYCLES - 1);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sampleCnt_q <= 16'h0000;
        end else begin
            sampleCnt_q <= sampleTick ? 16'h0000 : sampleCnt_q + 16'h0001; // RULE17
        end
    end

    // ----------------------------------------
    // regulator pipeline
    // ----------------------------------------
    strg_state_type state_q;
    logic signed [15:0] error_q;
    logic signed [15:0] prevRef_q;
    logic signed [15:0] refStep_q;
    logic signed [47:0] integ_q;
    logic signed [15:0] regOut_q;
    logic signed [15:0] torqueRef_q;
    strg_outputs_type out_q;
    logic signed [47:0] propTerm;
    logic signed [47:0] ffTerm;
    logic signed [47:0] scaledA;
    logic signed [47:0] scaledB;

    // gains are whole per-unit numbers, error is q12; ki rate is per second
    assign propTerm = 48'(error_q) * 48'(signed'({1'b0, kp_q})); // RULE3
    // damping opposes the reference step of the last sample, scaled by kf (q8)
    assign ffTerm = ctrl_q[`STRG_CTRL_AUTOTUNE] ? 48'sd0
                  : (48'(refStep_q) * 48'(signed'({1'b0, kf_q}))) >>> 8; // RULE6
    // zero-extend the unsigned settings so the arithmetic stays signed
    assign scaledA = strg_scale(ctlIn.torqueSrcA, aHi_q, aLo_q)
                   / ((aDiv_q == 16'h0000) ? 48'sd1 : 48'(signed'({1'b0, aDiv_q}))); // RULE14
    assign scaledB = strg_scale(ctlIn.torqueSrcB, bHi_q, bLo_q)
                   * 48'(signed'({1'b0, bMult_q})); // RULE15

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= STRG_IDLE;
        end else begin
            case (state_q)
                STRG_IDLE: state_q <= sampleTick ? STRG_PI : STRG_IDLE;
                STRG_PI: state_q <= STRG_SEL;
                STRG_SEL: state_q <= STRG_IDLE;
                default: state_q <= STRG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            error_q <= 16'sh0000;
            prevRef_q <= 16'sh0000;
            refStep_q <= 16'sh0000;
            torqueRef_q <= 16'sh0000;
        end else if (state_q == STRG_IDLE && sampleTick) begin
            error_q <= strg_sat(48'(ctlIn.speedRef) - 48'(ctlIn.speedFb)); // RULE1
            prevRef_q <= ctlIn.speedRef;
            refStep_q <= strg_sat(48'(ctlIn.speedRef) - 48'(prevRef_q)); // RULE6
            torqueRef_q <= strg_sat(scaledA + scaledB); // RULE16
        end
    end

    // integrator: ki * err * Ts, Ts = sample/1e6 s, kept with 16 extra bits
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            integ_q <= 48'sd0; // RULE17
            regOut_q <= 16'sh0000;
        end else if (state_q == STRG_PI) begin
            integ_q <= integ_q + ((48'(error_q) * 48'(signed'({1'b0, ki_q})) * 48'sd65536
                       * `STRG_SAMPLE_US) / 48'sd1000000); // RULE2
            regOut_q <= strg_sat(propTerm + (integ_q >>> 16) - ffTerm); // RULE1
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= '0;
        end else if (state_q == STRG_SEL) begin
            out_q.fluxOnly <= 1'b0;
            out_q.speedActive <= 1'b0;
            case (mode_q)
                3'(STRG_SPEED): begin
                    out_q.torqueCmd <= regOut_q; // RULE9
                    out_q.speedActive <= 1'b1;
                end
                3'(STRG_TORQUE): out_q.torqueCmd <= torqueRef_q; // RULE10
                3'(STRG_MIN): begin
                    out_q.torqueCmd <= (regOut_q < torqueRef_q) ? regOut_q : torqueRef_q; // RULE11
                    out_q.speedActive <= regOut_q < torqueRef_q; // RULE12
                end
                3'(STRG_MAX): begin
                    out_q.torqueCmd <= (regOut_q > torqueRef_q) ? regOut_q : torqueRef_q; // RULE11
                    out_q.speedActive <= regOut_q > torqueRef_q; // RULE12
                end
                3'(STRG_SUM): begin
                    out_q.torqueCmd <= strg_sat(48'(regOut_q) + 48'(torqueRef_q)); // RULE13
                    out_q.speedActive <= 1'b1;
                end
                default: begin
                    out_q.torqueCmd <= 16'sh0000; // RULE8 RULE17
                    out_q.fluxOnly <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wbDat_q <= 32'h00000000;
        end else begin
            case (wb_adr_i)
                `STRG_OFF_MODE: wbDat_q <= {29'h0, mode_q};
                `STRG_OFF_BW: wbDat_q <= {16'h0, bandwidth_q};
                `STRG_OFF_INERTIA: wbDat_q <= {16'h0, inertia_q};
                `STRG_OFF_KI: wbDat_q <= {16'h0, ki_q};
                `STRG_OFF_KP: wbDat_q <= {16'h0, kp_q};
                `STRG_OFF_KF: wbDat_q <= {16'h0, kf_q};
                `STRG_OFF_A_HI: wbDat_q <= {16'h0, aHi_q};
                `STRG_OFF_A_LO: wbDat_q <= {16'h0, aLo_q};
                `STRG_OFF_A_DIV: wbDat_q <= {16'h0, aDiv_q};
                `STRG_OFF_B_HI: wbDat_q <= {16'h0, bHi_q};
                `STRG_OFF_B_LO: wbDat_q <= {16'h0, bLo_q};
                `STRG_OFF_B_MULT: wbDat_q <= {16'h0, bMult_q};
                `STRG_OFF_CTRL: wbDat_q <= {30'h0, ctrl_q};
                `STRG_OFF_TORQUE: wbDat_q <= {16'h0, out_q.torqueCmd};
                `STRG_OFF_INTEG: wbDat_q <= integ_q[47:16];
                `STRG_OFF_STATUS: wbDat_q <= {30'h0, out_q.fluxOnly, out_q.speedActive};
                default: wbDat_q <= 32'h00000000;
            endcase
        end
    end

    assign wb_ack_o = wbAck_q;
    assign wb_dat_o = wbDat_q;
    assign ctlOut = out_q;
endmodule : strg_speed_torque_regulator

// *** pkg/strg_cfg.svh ***
// register offsets, reset values and timing counts of the speed/torque regulator
`ifndef STRG_CFG_SVH
`define STRG_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define STRG_OFF_MODE 8'h00
`define STRG_OFF_BW 8'h04
`define STRG_OFF_INERTIA 8'h08
`define STRG_OFF_KI 8'h0C
`define STRG_OFF_KP 8'h10
`define STRG_OFF_KF 8'h14
`define STRG_OFF_A_HI 8'h18
`define STRG_OFF_A_LO 8'h1C
`define STRG_OFF_A_DIV 8'h20
`define STRG_OFF_B_HI 8'h24
`define STRG_OFF_B_LO 8'h28
`define STRG_OFF_B_MULT 8'h2C
`define STRG_OFF_CTRL 8'h30
`define STRG_OFF_TORQUE 8'h34
`define STRG_OFF_INTEG 8'h38
`define STRG_OFF_STATUS 8'h3C
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define STRG_CTRL_AUTOTUNE 0
`define STRG_CTRL_INERTIA_TUNE 1
`define STRG_RST_KI 16'h0032
`define STRG_RST_KP 16'h0014
`define STRG_RST_KF 16'h0100
`define STRG_RST_INERTIA 16'h0100
`define STRG_RST_A_HI 16'h1000
`define STRG_RST_A_DIV 16'h0001
`define STRG_RST_B_HI 16'h1000
`define STRG_RST_B_MULT 16'h0001
// ----------------------------------------
// timing
// ----------------------------------------
`define STRG_CLOCK_HZ 50000000
`define STRG_SAMPLE_US 125
`define STRG_SAMPLE_CYCLES ((`STRG_CLOCK_HZ / 1000000) * `STRG_SAMPLE_US)
`endif

// *** pkg/strg_pkg.sv ***
// types of the speed/torque regulator
package strg_pkg;
    typedef enum logic [2:0] {
        STRG_ZERO,
        STRG_SPEED,
        STRG_TORQUE,
        STRG_MIN,
        STRG_MAX,
        STRG_SUM
    } strg_mode_type;

    typedef enum {
        STRG_IDLE,
        STRG_PI,
        STRG_SEL
    } strg_state_type;

    typedef struct packed {
        logic signed [15:0] speedRef;
        logic signed [15:0] speedFb;
        logic signed [15:0] torqueSrcA;
        logic signed [15:0] torqueSrcB;
    } strg_inputs_type;

    typedef struct packed {
        logic signed [15:0] torqueCmd;
        logic fluxOnly;
        logic speedActive;
    } strg_outputs_type;
endpackage : strg_pkg

// *** verif/strg_motor_model.sv ***
// torque stage and shaft model that returns speed feedback
`timescale 1ns/1ns
module strg_motor_model
    import strg_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic signed [15:0] torqueCmd,
    input wire logic freeze,
    input wire logic signed [15:0] fbSet,
    output logic signed [15:0] speedFb
);
    // frozen shaft follows the bench, free shaft integrates torque
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) speedFb <= 16'sh0;
        else if (freeze) speedFb <= fbSet;
        else speedFb <= speedFb + (torqueCmd >>> 10);
    end
endmodule : strg_motor_model

// *** verif/strg_speed_torque_regulator_props.sv ***
// port assertions of the speed/torque regulator
`timescale 1ns/1ns
module strg_speed_torque_regulator_props
    import strg_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire strg_outputs_type ctlOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h3C |->
        wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 8'h38 |->
        wb_dat_o[31:16] == 16'h0) else $error("upper read bits not zero");
    chk_zero_torque: assert property (ctlOut.fluxOnly |-> ctlOut.torqueCmd == 16'sh0)
        else $error("torque with flux only");
    chk_flux_exclusive: assert property (ctlOut.fluxOnly |-> !ctlOut.speedActive)
        else $error("speed active with flux only");
    chk_out_once: assert property ($changed(ctlOut) |=> $stable(ctlOut) [*8])
        else $error("output changed twice in a sample");
    chk_reset_clear: assert property ($rose(reset_n) |-> ctlOut == '0)
        else $error("output not cleared by reset");
endmodule : strg_speed_torque_regulator_props

bind strg_speed_torque_regulator strg_speed_torque_regulator_props chk_u (
    .clock(clock), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .ctlOut(ctlOut));

// *** verif/test_speed_torque_regulator.sv ***
// self-checking bench of the speed/torque regulator
`timescale 1ns/1ns
`include "strg_cfg.svh"
module test_speed_torque_regulator
    import strg_pkg::*;
;
    logic clock = 0, reset_n = 0, we = 0, cyc = 0, stb = 0, ack, inValid = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, seed = 32'h0000003B;
    logic [15:0] inMeas = 16'h0;
    logic signed [15:0] fbSet = 16'sh0, fb, srcA, srcB, tref;
    logic signed [15:0] spRef = 16'sh0, tqA = 16'sh0, tqB = 16'sh0;
    strg_inputs_type ctlIn;
    strg_outputs_type ctlOut;
    int err_count = 0, cmp_count = 0, cycles = 0, m = 0;
    strg_speed_torque_regulator dut_u (.clock(clock), .reset_n(reset_n), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'h3), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .ctlIn(ctlIn), .inertiaValid(inValid),
        .inertiaMeasured(inMeas), .ctlOut(ctlOut));
    strg_motor_model motor_u (.clock(clock), .reset_n(reset_n), .torqueCmd(ctlOut.torqueCmd),
        .freeze(1'b1), .fbSet(fbSet), .speedFb(fb));
    always #10 clock = ~clock;
    assign ctlIn = {spRef, fb, tqA, tqB};
    always @(posedge clock) begin
        cycles++;
        if (cycles == 95000) begin
            err_count++;
            summarize();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic signed [15:0] expCmd(int m, logic signed [15:0] r, t);
        case (m)
            1: return r;
            2: return t;
            3: return (r < t) ? r : t;
            4: return (r > t) ? r : t;
            5: return r + t;
            default: return 16'sh0;
        endcase
    endfunction : expCmd
    function automatic logic expAct(int m, logic signed [15:0] r, t);
        case (m)
            1, 5: return 1'b1;
            3: return r < t;
            4: return r > t;
            default: return 1'b0;
        endcase
    endfunction : expAct
    task automatic wbx(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge clock); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wbx
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        wbx(a, 1'b0, 32'h0);
        chk(rdat, {16'h0, exp});
    endtask : rd
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd(`STRG_OFF_KI, 16'h0032);
        rd(`STRG_OFF_KP, 16'h0014);
        rd(8'h40, 16'h0);
        wbx(`STRG_OFF_BW, 1'b1, 32'h8);
        rd(`STRG_OFF_KP, 16'h0008);
        wbx(`STRG_OFF_KI, 1'b1, 32'h55);
        rd(`STRG_OFF_KI, 16'h0010);
        wbx(`STRG_OFF_INERTIA, 1'b1, 32'h200);
        rd(`STRG_OFF_KI, 16'h0020);
        rd(`STRG_OFF_KP, 16'h0010);
        wbx(`STRG_OFF_BW, 1'b1, 32'h0);
        wbx(`STRG_OFF_KI, 1'b1, 32'h0);
        wbx(`STRG_OFF_KP, 1'b1, 32'h14);
        rd(`STRG_OFF_KP, 16'h0014);
        wbx(`STRG_OFF_CTRL, 1'b1, 32'h3);
        @(posedge clock);
        inMeas <= 16'h0300;
        inValid <= 1'b1;
        @(posedge clock);
        inValid <= 1'b0;
        rd(`STRG_OFF_INERTIA, 16'h0300);
        wbx(`STRG_OFF_A_HI, 1'b1, 32'h800);
        wbx(`STRG_OFF_A_DIV, 1'b1, 32'h2);
        wbx(`STRG_OFF_B_MULT, 1'b1, 32'h3);
        // error of 16 counts, feed-forward held open, integral gain zero
        for (int k = 0; k < 10; k++) begin
            m = (k < 8) ? k : k - 5;
            srcA = 16'(xs() & 32'h3FC);
            srcB = (k < 8) ? -16'sd1 - 16'(xs() & 32'h1FF) : 16'sh0100;
            tref = (srcA >>> 2) + 16'sd3 * srcB;
            spRef <= 16'sh0100;
            tqA <= srcA;
            tqB <= srcB;
            fbSet <= 16'sh00F0;
            wbx(`STRG_OFF_MODE, 1'b1, m);
            repeat (`STRG_SAMPLE_CYCLES + 10) @(posedge clock);
            chk(ctlOut.torqueCmd, expCmd(m, 16'sd320, tref));
            chk(ctlOut.fluxOnly, (m == 0 || m > 5));
            chk(ctlOut.speedActive, expAct(m, 16'sd320, tref));
            rd(`STRG_OFF_TORQUE, expCmd(m, 16'sd320, tref));
            rd(`STRG_OFF_STATUS, {14'h0, m == 0 || m > 5, expAct(m, 16'sd320, tref)});
        end
        // reset in mid-run clears the regulator output and returns the settings to their reset values
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk(ctlOut, 32'h0);
        rd(`STRG_OFF_MODE, 16'h0);
        rd(`STRG_OFF_A_DIV, `STRG_RST_A_DIV);
        summarize();
    end
endmodule : test_speed_torque_regulator
